// >>> core/sapb_page_builder.sv
// Purpose: builds the 512-byte attribute value and threshold pages
// Assumes: subcommand strobe and host stream are synchronous to clk
// Notes: entries are loaded over wishbone, streamed one byte per beat
// Operation
// - each page is 512 bytes, version first
// - value entry: id, flags, cur, worst, raw
// - value tail: reserved, capability word, vendor, checksum
// - threshold entry: id, threshold, reserved; tail
// - same version number in both pages
// - identifier zero marks an unused entry
// - status flag bit 0 in-range, others reserved
// - current value confined to 01h through 64h
// - healthy only when current exceeds threshold
// - worst value tracks lowest value seen
// - capability bits: power-save save, periodic save
// - last byte makes page sum zero
// - d0h returns values, d1h returns thresholds
// - value read: busy, capture, release, send
`timescale 1ns/1ps
module sapb_page_builder
    import sapb_pkg::*;
#(
    parameter int NUM_ENT = SAPB_NUM_ENT,
    parameter logic [15:0] FMT_VERSION = SAPB_VERSION_DEF
) (
    input wire logic clk, // core clock, 20 mhz
    input wire logic rst, // sync reset, high
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write
    input wire logic wb_stb_i, // strobe
    input wire logic wb_cyc_i, // cycle
    output logic wb_ack_o, // acknowledge
    input wire logic [7:0] feature_select_register, // subcommand
    input wire logic cmd_strobe, // subcommand issued
    output logic busy_indicator, // capture in progress
    output logic pred_fail, // some attribute at or below threshold
    output logic [7:0] page_data, // page byte
    output logic page_last, // final byte of page
    output logic page_valid, // byte offered
    input wire logic page_ready // host takes byte
);
    sapb_state_e state_r, state_nxt;
    logic [7:0] id_m [NUM_ENT];
    logic flag_m [NUM_ENT];
    logic [7:0] pend_m [NUM_ENT];
    logic [7:0] cur_m [NUM_ENT];
    logic [7:0] worst_m [NUM_ENT];
    logic [47:0] raw_m [NUM_ENT];
    logic [7:0] thr_m [NUM_ENT];
    logic [1:0] cap_r;
    logic [4:0] sel_r, cap_idx_r, ent_r;
    logic [8:0] byte_r;
    logic [3:0] off_r;
    logic [7:0] sum_r;
    logic page_thr_r, rej_r, ack_r;
    logic wb_hit, wb_wr, sel_ok, cmd_go, cmd_rej, rej_clr;
    logic in_ent, is_last, push, buf_ready, any_fail;
    logic [31:0] wdat, rd_data;
    logic [7:0] beat_byte, cap_pend, cap_worst;
    logic [5:0] raw_bit;
    sapb_beat_s beat_in, beat_out;

    // confine a normalised value to its legal range
    function automatic logic [7:0] clamp_val(input logic [7:0] v);
        if (v < SAPB_VAL_MIN) return SAPB_VAL_MIN;
        if (v > SAPB_VAL_MAX) return SAPB_VAL_MAX;
        return v;
    endfunction

    // bus decode; one wait state so read data comes from a flop, writes land with ack
    assign wb_hit = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i;
    assign sel_ok = sel_r < 5'(NUM_ENT);
    assign wdat = {wb_sel_i[3] ? wb_dat_i[31:24] : 8'h00,
                   wb_sel_i[2] ? wb_dat_i[23:16] : 8'h00,
                   wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                   wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    assign rej_clr = wb_wr && wb_adr_i == SAPB_A_STAT && wb_sel_i[0]
        && wb_dat_i[SAPB_ST_REJ];

    // subcommand acceptance; anything else or a clash is refused
    assign cmd_go = cmd_strobe && state_r == SAPB_IDLE
        && (feature_select_register == SAPB_SUB_VAL
            || feature_select_register == SAPB_SUB_THR);
    assign cmd_rej = cmd_strobe && !cmd_go;

    // register read selection
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            SAPB_A_CTRL: rd_data = {30'h0, cap_r};
            SAPB_A_SEL: rd_data = {27'h0, sel_r};
            SAPB_A_ID: rd_data = sel_ok ? {23'h0, flag_m[sel_r], id_m[sel_r]} : 32'h0;
            SAPB_A_VAL: rd_data = sel_ok
                ? {8'h00, pend_m[sel_r], worst_m[sel_r], cur_m[sel_r]} : 32'h0;
            SAPB_A_RAW_LO: rd_data = sel_ok ? raw_m[sel_r][31:0] : 32'h0;
            SAPB_A_RAW_HI: rd_data = sel_ok ? {16'h0, raw_m[sel_r][47:32]} : 32'h0;
            SAPB_A_THR: rd_data = sel_ok ? {24'h0, thr_m[sel_r]} : 32'h0;
            SAPB_A_STAT: rd_data = {28'h0, rej_r, pred_fail,
                state_r == SAPB_SEND, busy_indicator};
            SAPB_A_VER: rd_data = {16'h0, FMT_VERSION};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // wishbone answer; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_r <= wb_hit;
            wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_r;

    // control registers; refused-command flag: a new refusal beats clear
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_r <= 2'h0;
            sel_r <= 5'h00;
            rej_r <= 1'b0;
        end else begin
            if (wb_wr && wb_adr_i == SAPB_A_CTRL) cap_r <= wdat[1:0];
            if (wb_wr && wb_adr_i == SAPB_A_SEL && wb_sel_i[0]) sel_r <= wdat[4:0];
            rej_r <= cmd_rej || (rej_r && !rej_clr);
        end
    end

    // entry table: bus loads ids, flags, pending values, raw, thresholds
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_ENT; i++) begin
                id_m[i] <= 8'h00;
                flag_m[i] <= 1'b0;
                pend_m[i] <= SAPB_VAL_RST;
                raw_m[i] <= 48'h0;
                thr_m[i] <= SAPB_THR_RST;
            end
        end else if (wb_wr && sel_ok) begin
            case (wb_adr_i)
                SAPB_A_ID: begin
                    if (wb_sel_i[0]) id_m[sel_r] <= wdat[7:0];
                    if (wb_sel_i[1]) flag_m[sel_r] <= wdat[8];
                end
                SAPB_A_VAL: if (wb_sel_i[0]) pend_m[sel_r] <= clamp_val(wdat[7:0]);
                SAPB_A_RAW_LO: raw_m[sel_r][31:0] <= wdat;
                SAPB_A_RAW_HI: raw_m[sel_r][47:32] <= wdat[15:0];
                SAPB_A_THR: if (wb_sel_i[0]) thr_m[sel_r] <= wdat[7:0];
                default: ;
            endcase
        end
    end

    // capture moves pending values in, one entry a cycle, while busy
    assign cap_pend = pend_m[cap_idx_r];
    assign cap_worst = worst_m[cap_idx_r];
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_ENT; i++) begin
                cur_m[i] <= SAPB_VAL_RST;
                worst_m[i] <= SAPB_VAL_RST;
            end
        end else if (state_r == SAPB_CAPT) begin
            cur_m[cap_idx_r] <= cap_pend;
            if (cap_pend < cap_worst) worst_m[cap_idx_r] <= cap_pend;
        end
    end

    // failure criterion over used entries only
    always_comb begin
        any_fail = 1'b0;
        for (int i = 0; i < NUM_ENT; i++) begin
            if (id_m[i] != 8'h00 && cur_m[i] <= thr_m[i]) any_fail = 1'b1;
        end
    end

    // sequencing: idle, capture under busy (d0h only; d1h goes straight to send), then send the page
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SAPB_IDLE: if (cmd_go) begin
                state_nxt = feature_select_register == SAPB_SUB_VAL
                    ? SAPB_CAPT : SAPB_SEND;
            end
            SAPB_CAPT: if (cap_idx_r == 5'(NUM_ENT - 1)) state_nxt = SAPB_SEND;
            SAPB_SEND: if (push && is_last) state_nxt = SAPB_IDLE;
            default: state_nxt = SAPB_IDLE;
        endcase
    end

    // page position and layout decode
    assign in_ent = byte_r >= SAPB_B_ENT_FIRST && byte_r <= SAPB_B_ENT_LAST;
    assign is_last = byte_r == SAPB_B_CSUM;
    assign push = state_r == SAPB_SEND && buf_ready;
    assign raw_bit = {3'(off_r - SAPB_O_RAW), 3'b000};

    // byte of the page at the current position; unlisted bytes read zero
    always_comb begin
        beat_byte = 8'h00;
        if (byte_r == SAPB_B_VER_LO) begin
            beat_byte = FMT_VERSION[7:0];
        end else if (byte_r == SAPB_B_VER_HI) begin
            beat_byte = FMT_VERSION[15:8];
        end else if (in_ent && page_thr_r) begin
            if (off_r == SAPB_O_ID) beat_byte = id_m[ent_r];
            else if (off_r == SAPB_O_THR) beat_byte = thr_m[ent_r];
        end else if (in_ent) begin
            if (off_r == SAPB_O_ID) beat_byte = id_m[ent_r];
            else if (off_r == SAPB_O_FLAG_LO) beat_byte = {7'h00, flag_m[ent_r]};
            else if (off_r == SAPB_O_CUR) beat_byte = cur_m[ent_r];
            else if (off_r == SAPB_O_WORST) beat_byte = worst_m[ent_r];
            else if (off_r >= SAPB_O_RAW && off_r <= SAPB_O_RAW_END)
                beat_byte = raw_m[ent_r][raw_bit +: 8];
        end else if (!page_thr_r && byte_r == SAPB_B_CAP_LO) begin
            beat_byte = {6'h00, cap_r};
        end else if (is_last) begin
            beat_byte = 8'h00 - sum_r;
        end
    end
    assign beat_in = '{last: is_last, data: beat_byte};

    // state and counters; page counters advance only on an accepted beat, capture index once per capture cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= SAPB_IDLE;
            busy_indicator <= 1'b0;
            pred_fail <= 1'b0;
            page_thr_r <= 1'b0;
            cap_idx_r <= 5'h00;
            byte_r <= 9'h000;
            ent_r <= 5'h00;
            off_r <= 4'h0;
            sum_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            busy_indicator <= state_nxt == SAPB_CAPT;
            pred_fail <= any_fail;
            if (cmd_go) begin
                page_thr_r <= feature_select_register == SAPB_SUB_THR;
                cap_idx_r <= 5'h00;
                byte_r <= 9'h000;
                ent_r <= 5'h00;
                off_r <= 4'h0;
                sum_r <= 8'h00;
            end
            if (state_r == SAPB_CAPT) cap_idx_r <= cap_idx_r + 5'h01;
            if (push) begin
                byte_r <= byte_r + 9'h001;
                sum_r <= sum_r + beat_byte;
                if (in_ent && off_r == SAPB_O_LAST) begin
                    off_r <= 4'h0;
                    ent_r <= ent_r + 5'h01;
                end else if (in_ent) begin
                    off_r <= off_r + 4'h1;
                end
            end
        end
    end

    // stall by the host backs up here and freezes the framer counters
    sapb_buf2 u_buf (
        .clk(clk),
        .rst(rst),
        .in_beat(beat_in),
        .in_valid(state_r == SAPB_SEND),
        .in_ready(buf_ready),
        .out_beat(beat_out),
        .out_valid(page_valid),
        .out_ready(page_ready)
    );
    assign page_data = beat_out.data;
    assign page_last = beat_out.last;

    // helper: count and sum of bytes the host has taken in this page
    logic [8:0] got_cnt_r;
    logic [7:0] got_sum_r;
    logic [4:0] cap_idx_d;
    logic take;
    assign take = page_valid && page_ready;
    always_ff @(posedge clk) begin
        if (rst || (take && page_last)) begin
            got_cnt_r <= 9'h000;
            got_sum_r <= 8'h00;
        end else if (take) begin
            got_cnt_r <= got_cnt_r + 9'h001;
            got_sum_r <= got_sum_r + page_data;
        end
        cap_idx_d <= cap_idx_r;
    end

    page_len_a: assert property (@(posedge clk) disable iff (rst)
        take |-> page_last == (got_cnt_r == 9'h1ff))
        else $error("page length is not 512 bytes");
    page_sum_a: assert property (@(posedge clk) disable iff (rst)
        take && page_last |-> 8'(got_sum_r + page_data) == 8'h00)
        else $error("page does not sum to zero");
    version_lo_a: assert property (@(posedge clk) disable iff (rst)
        take && got_cnt_r == 9'h000 |-> page_data == FMT_VERSION[7:0])
        else $error("version low byte wrong");
    busy_seq_a: assert property (@(posedge clk) disable iff (rst)
        cmd_go && feature_select_register == SAPB_SUB_VAL
        |=> busy_indicator && !page_valid ##29 busy_indicator ##1 !busy_indicator)
        else $error("busy window not thirty cycles");
    thr_busy_a: assert property (@(posedge clk) disable iff (rst)
        cmd_go && feature_select_register == SAPB_SUB_THR |=> !busy_indicator && page_thr_r)
        else $error("threshold read raised busy");
    worst_upd_a: assert property (@(posedge clk) disable iff (rst)
        state_r == SAPB_CAPT && cap_pend < cap_worst
        |=> worst_m[cap_idx_d] == $past(cap_pend))
        else $error("worst value not updated");
    cur_range_a: assert property (@(posedge clk) disable iff (rst)
        state_r == SAPB_CAPT |-> cap_pend >= SAPB_VAL_MIN && cap_pend <= SAPB_VAL_MAX)
        else $error("current value out of range");
    thr_rsvd_a: assert property (@(posedge clk) disable iff (rst)
        push && page_thr_r && in_ent && off_r > SAPB_O_THR |-> beat_byte == 8'h00)
        else $error("threshold entry reserved byte not zero");
    flag_hi_a: assert property (@(posedge clk) disable iff (rst)
        push && !page_thr_r && in_ent && off_r == 4'h2 |-> beat_byte == 8'h00)
        else $error("status flag high byte not zero");
    cap_word_a: assert property (@(posedge clk) disable iff (rst)
        push && !page_thr_r && byte_r == SAPB_B_CAP_LO |-> beat_byte == {6'h00, cap_r})
        else $error("capability word wrong");
    fail_flag_a: assert property (@(posedge clk) disable iff (rst)
        id_m[0] != 8'h00 && cur_m[0] <= thr_m[0] |=> pred_fail)
        else $error("failing entry not flagged");
    val_page_c: cover property (@(posedge clk) disable iff (rst)
        take && page_last && !page_thr_r);
    thr_page_c: cover property (@(posedge clk) disable iff (rst)
        take && page_last && page_thr_r);
    stall_c: cover property (@(posedge clk) disable iff (rst)
        state_r == SAPB_SEND && !buf_ready);
    rej_c: cover property (@(posedge clk) disable iff (rst) cmd_rej);
endmodule

// >>> core/sapb_pkg.sv
// Purpose: shared constants and types of the attribute page builder
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes: page byte positions are hex offsets within one 512-byte page
package sapb_pkg;
    localparam int SAPB_NUM_ENT = 30;
    localparam logic [15:0] SAPB_VERSION_DEF = 16'h0001;
    // feature subcommands
    localparam logic [7:0] SAPB_SUB_VAL = 8'hd0;
    localparam logic [7:0] SAPB_SUB_THR = 8'hd1;
    // page byte positions
    localparam logic [8:0] SAPB_B_VER_LO = 9'h000;
    localparam logic [8:0] SAPB_B_VER_HI = 9'h001;
    localparam logic [8:0] SAPB_B_ENT_FIRST = 9'h002;
    localparam logic [8:0] SAPB_B_ENT_LAST = 9'h169;
    localparam logic [8:0] SAPB_B_CAP_LO = 9'h170;
    localparam logic [8:0] SAPB_B_CSUM = 9'h1ff;
    // byte offsets inside one twelve-byte entry
    localparam logic [3:0] SAPB_O_ID = 4'h0;
    localparam logic [3:0] SAPB_O_FLAG_LO = 4'h1;
    localparam logic [3:0] SAPB_O_THR = 4'h1;
    localparam logic [3:0] SAPB_O_CUR = 4'h3;
    localparam logic [3:0] SAPB_O_WORST = 4'h4;
    localparam logic [3:0] SAPB_O_RAW = 4'h5;
    localparam logic [3:0] SAPB_O_RAW_END = 4'ha;
    localparam logic [3:0] SAPB_O_LAST = 4'hb;
    // normalised value range and reset values
    localparam logic [7:0] SAPB_VAL_MIN = 8'h01;
    localparam logic [7:0] SAPB_VAL_MAX = 8'h64;
    localparam logic [7:0] SAPB_VAL_RST = 8'h64;
    localparam logic [7:0] SAPB_THR_RST = 8'h00;
    // register byte addresses
    localparam logic [7:0] SAPB_A_CTRL = 8'h00;
    localparam logic [7:0] SAPB_A_SEL = 8'h04;
    localparam logic [7:0] SAPB_A_ID = 8'h08;
    localparam logic [7:0] SAPB_A_VAL = 8'h0c;
    localparam logic [7:0] SAPB_A_RAW_LO = 8'h10;
    localparam logic [7:0] SAPB_A_RAW_HI = 8'h14;
    localparam logic [7:0] SAPB_A_THR = 8'h18;
    localparam logic [7:0] SAPB_A_STAT = 8'h1c;
    localparam logic [7:0] SAPB_A_VER = 8'h20;
    // status register bit positions
    localparam int SAPB_ST_BUSY = 0;
    localparam int SAPB_ST_SEND = 1;
    localparam int SAPB_ST_FAIL = 2;
    localparam int SAPB_ST_REJ = 3;

    typedef enum logic [1:0] {
        SAPB_IDLE = 2'b00,
        SAPB_CAPT = 2'b01,
        SAPB_SEND = 2'b11
    } sapb_state_e;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } sapb_beat_s;
endpackage

// >>> core/sapb_buf2.sv
// Purpose: two-entry buffer between page framer and host stream
// Assumes: source honours in_ready, sink may stall at any time
// Notes: head entry is a flop, so outputs come straight from registers
`timescale 1ns/1ps
module sapb_buf2
    import sapb_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst, // sync reset, high
    input wire sapb_beat_s in_beat, // beat from framer
    input wire logic in_valid, // framer offers a beat
    output logic in_ready, // room for a beat
    output sapb_beat_s out_beat, // head beat
    output logic out_valid, // head holds a beat
    input wire logic out_ready // sink takes head
);
    sapb_beat_s d1_r;
    logic v1_r;
    logic push;
    logic pop;

    // ready only from the spare slot flag, so no combinational path
    assign in_ready = !v1_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // shift spare into head on pop, fill the first free slot on push
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            v1_r <= 1'b0;
            out_beat <= '0;
            d1_r <= '0;
        end else if (pop && v1_r) begin
            out_beat <= d1_r;
            if (push) d1_r <= in_beat;
            else v1_r <= 1'b0;
        end else if (pop) begin
            if (push) out_beat <= in_beat;
            else out_valid <= 1'b0;
        end else if (push && !out_valid) begin
            out_beat <= in_beat;
            out_valid <= 1'b1;
        end else if (push) begin
            d1_r <= in_beat;
            v1_r <= 1'b1;
        end
    end

    hold_stall_a: assert property (@(posedge clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_beat))
        else $error("head beat changed while stalled");
    full_block_a: assert property (@(posedge clk) disable iff (rst)
        out_valid && v1_r && !out_ready |=> !in_ready && $stable(d1_r))
        else $error("full buffer accepted a beat");
    buf_full_c: cover property (@(posedge clk) disable iff (rst) v1_r && in_valid);
endmodule

// >>> testbench/sapb_host_model.sv
// Purpose: host controller model that reads page bytes from the block
// Assumes: a byte is taken on each edge where valid and ready are high
// Notes: slow mode stalls two cycles in three, which fills the buffer
`timescale 1ns/1ps
module sapb_host_model (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset, high
    input wire logic slow, // stall often
    input wire logic [7:0] page_data, // page byte
    input wire logic page_last, // final byte flag
    input wire logic page_valid, // byte offered
    output logic page_ready = 1'b0 // byte taken
);
    logic [7:0] got[512];
    int n = 0;
    int last_at = -1;
    int cnt = 0;
    // called only while no page is moving
    task automatic clear();
        n = 0;
        last_at = -1;
    endtask
    // bytes kept in arrival order, a page is taken whole
    always @(posedge clk) begin
        cnt <= cnt + 1;
        page_ready <= !rst && (!slow || cnt % 3 == 0);
        if (!rst && page_valid && page_ready) begin
            if (n < 512) got[n] <= page_data;
            if (page_last) last_at <= n;
            n <= n + 1;
        end
    end
endmodule

// >>> testbench/smart_attribute_page_builder_tb.sv
// Purpose: self-checking bench of the attribute page builder
// Assumes: classic wishbone master, pages read by the host model
// Notes: a table model predicts every page byte and register read
`timescale 1ns/1ps
module smart_attribute_page_builder_tb;
    import sapb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] feature_select_register = 8'h00;
    logic cmd_strobe = 1'b0;
    logic busy_indicator, pred_fail, page_last, page_valid, page_ready;
    logic [7:0] page_data;
    logic slow = 1'b0;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] seed = 32'd76677;
    int id[30], flg[30], pnd[30], cur[30], wst[30], thr[30], pg[512];
    logic [47:0] raw[30];
    int cap = 0;
    int rej = 0;
    sapb_page_builder dut_u (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
        .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .feature_select_register,
        .cmd_strobe, .busy_indicator, .pred_fail, .page_data, .page_last, .page_valid,
        .page_ready);
    sapb_host_model host_u (.clk, .rst, .slow, .page_data, .page_last, .page_valid,
        .page_ready);
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic tmo();
        miscompares++;
        finish_test();
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (k == 20) tmo();
    endtask
    function automatic logic pf();
        pf = 1'b0;
        for (int i = 0; i < 30; i++) if (id[i] != 0 && cur[i] <= thr[i]) pf = 1'b1;
    endfunction
    // expected page; reserved and vendor bytes stay zero
    task automatic build(input bit t);
        int s;
        s = 0;
        for (int b = 0; b < 512; b++) pg[b] = 0;
        pg[0] = SAPB_VERSION_DEF[7:0];
        pg[1] = SAPB_VERSION_DEF[15:8];
        for (int i = 0; i < 30; i++) begin
            pg[2+12*i] = id[i];
            if (t) pg[3+12*i] = thr[i];
            else begin
                pg[3+12*i] = flg[i];
                pg[5+12*i] = cur[i];
                pg[6+12*i] = wst[i];
                for (int j = 0; j < 6; j++) pg[7+12*i+j] = raw[i][8*j +: 8];
            end
        end
        if (!t) pg[9'h170] = cap;
        for (int b = 0; b < 511; b++) s += pg[b];
        pg[511] = (256 - s % 256) % 256;
    endtask
    task automatic load();
        logic [31:0] q, a, b;
        for (int i = 0; i < 30; i++) begin
            a = xs();
            b = xs();
            id[i] = (i % 7 == 3) ? 0 : int'(a[31:24] | 8'h01);
            flg[i] = a[0];
            pnd[i] = (i == 0) ? 0 : (i == 2) ? 255 : int'(a[15:8]);
            raw[i] = {a[23:8], b};
            thr[i] = int'(b[6:0]) + 1;
            wb(1'b1, SAPB_A_SEL, 32'(i), q);
            wb(1'b1, SAPB_A_ID, 32'(flg[i] * 256 + id[i]), q);
            wb(1'b1, SAPB_A_VAL, 32'(pnd[i]), q);
            wb(1'b1, SAPB_A_RAW_LO, raw[i][31:0], q);
            wb(1'b1, SAPB_A_RAW_HI, {16'h0, raw[i][47:32]}, q);
            wb(1'b1, SAPB_A_THR, 32'(thr[i]), q);
            pnd[i] = pnd[i] < 1 ? 1 : pnd[i] > 100 ? 100 : pnd[i];
        end
    endtask
    // issue a subcommand, poke a second one mid-way, read the page
    task automatic run(input logic [7:0] code, input bit poke);
        int nb, k;
        nb = 0;
        host_u.clear();
        @(posedge clk);
        feature_select_register <= code;
        cmd_strobe <= 1'b1;
        @(posedge clk);
        cmd_strobe <= 1'b0;
        for (k = 0; k < 3000 && host_u.n < 512; k++) begin
            @(posedge clk);
            cmd_strobe <= (k == 6 && poke);
            feature_select_register <= SAPB_SUB_VAL;
            if (busy_indicator === 1'b1) nb += (host_u.n > 0) ? 100 : 1;
        end
        if (k == 3000) tmo();
        if (poke) rej = 1;
        if (code == SAPB_SUB_VAL) for (int i = 0; i < 30; i++) begin
            cur[i] = pnd[i];
            if (pnd[i] < wst[i]) wst[i] = pnd[i];
        end
        chk(32'(nb), code == SAPB_SUB_VAL ? 32'd30 : 32'd0);
        build(code == SAPB_SUB_THR);
        for (k = 0; k < 512; k++) chk({24'h0, host_u.got[k]}, 32'(pg[k]));
        chk(32'(host_u.last_at), 32'd511);
    endtask
    initial begin
        logic [31:0] q;
        for (int i = 0; i < 30; i++) begin
            id[i] = 0;
            flg[i] = 0;
            pnd[i] = 100;
            cur[i] = 100;
            wst[i] = 100;
            thr[i] = 0;
            raw[i] = 48'h0;
        end
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, SAPB_A_VER, 32'h0, q);
        chk(q, {16'h0, SAPB_VERSION_DEF});
        wb(1'b1, 8'h24, 32'hffffffff, q);
        wb(1'b0, 8'h24, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, SAPB_A_SEL, 32'd30, q);
        wb(1'b0, SAPB_A_VAL, 32'h0, q);
        chk(q, 32'h0);
        run(SAPB_SUB_THR, 1'b0);
        for (int r = 0; r < 2; r++) begin
            load();
            cap = int'(xs() & 32'h3);
            wb(1'b1, SAPB_A_CTRL, 32'(cap), q);
            slow <= r[0];
            run(SAPB_SUB_VAL, r == 1);
            slow <= !r[0];
            run(SAPB_SUB_THR, r == 0);
            for (int i = 0; i < 30; i++) begin
                wb(1'b1, SAPB_A_SEL, 32'(i), q);
                wb(1'b0, SAPB_A_VAL, 32'h0, q);
                chk(q, 32'(pnd[i] * 65536 + wst[i] * 256 + cur[i]));
            end
            chk({31'h0, pred_fail}, {31'h0, pf()});
            wb(1'b0, SAPB_A_STAT, 32'h0, q);
            chk(q, {28'h0, rej[0], pf(), 2'b00});
            wb(1'b1, SAPB_A_STAT, 32'h8, q);
            rej = 0;
        end
        @(posedge clk);
        feature_select_register <= 8'hd2;
        cmd_strobe <= 1'b1;
        @(posedge clk);
        cmd_strobe <= 1'b0;
        wb(1'b0, SAPB_A_STAT, 32'h0, q);
        chk(q, {28'h0, 1'b1, pf(), 2'b00});
        finish_test();
    end
endmodule
